// *** design/isx_pkg.sv ***
// constants and types for the increment-skip and or-literal execution datapath
//
// Summary of operation
// - decode increment-skip opcode with destination, 7-bit address
// - increment addressed file register, flags left alone
// - destination 0 to accumulator, 1 to file
// - zero result turns next cycle into no-op
// - decode, read, compute, write; skip cycle idle
// - OR literal into accumulator, update zero flag
// - decode or-literal opcode, single instruction cycle
// - four clock periods form one instruction cycle
package isx_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int INSTR_WIDTH = 14;   // one program word
   localparam int DATA_WIDTH = 8;     // file register and accumulator width
   localparam int ADDR_WIDTH = 7;     // file address, 0 to 127

   // ----------------------------------------------------------------
   // opcode patterns, upper six bits of the word
   // ----------------------------------------------------------------
   localparam logic [5:0] INCR_SKIP_OPCODE = 6'h0f;  // 00 1111 dfff ffff
   localparam logic [5:0] OR_LITERAL_OPCODE = 6'h38; // 11 1000 kkkk kkkk
   localparam int OPCODE_LSB = 8;     // opcode field starts here
   localparam int DEST_BIT = 7;       // destination select position

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [DATA_WIDTH-1:0] ACC_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'h0;
   localparam int QUARTERS_PER_CYCLE = 4; // clock periods per instruction cycle

   // quarter phase of the instruction cycle
   typedef enum logic [1:0] {
      PH_ONE,
      PH_TWO,
      PH_THREE,
      PH_FOUR
   } isx_phase_type;

   // instruction held for the current cycle
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_INCR,
      OP_OR
   } isx_kind_type;

   // complete state of the datapath
   typedef struct packed {
      isx_phase_type phase;            // current quarter
      logic skip;                      // this cycle is a forced no-op
      isx_kind_type kind;              // decoded instruction
      logic dest;                      // 1 writes file, 0 writes accumulator
      logic [ADDR_WIDTH-1:0] addr;     // file address
      logic [DATA_WIDTH-1:0] literal;  // literal field
      logic [DATA_WIDTH-1:0] operand;  // value read in quarter two
      logic [DATA_WIDTH-1:0] result;   // value computed in quarter three
      logic [DATA_WIDTH-1:0] acc;      // working accumulator
      logic zero;                      // zero flag
   } isx_state_type;

endpackage

// *** design/isx_exec.sv ***
// execution datapath for the increment-skip and or-literal instructions
`timescale 1ns/1ps
`default_nettype none

module isx_exec
   import isx_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // instruction word, held by the fetch side during quarter one
   input wire logic [INSTR_WIDTH-1:0] instrWord,
   // file register port
   output logic [ADDR_WIDTH-1:0] fileAddr,
   output logic fileRdEn,
   input wire logic [DATA_WIDTH-1:0] fileRdData,
   output logic fileWrEn,
   output logic [DATA_WIDTH-1:0] fileWrData,
   // architectural state
   output logic [DATA_WIDTH-1:0] accumulator,
   output logic zeroFlag,
   // cycle timing
   output logic quarterPhaseOne,
   output logic quarterPhaseTwo,
   output logic quarterPhaseThree,
   output logic quarterPhaseFour,
   output logic skipActive
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   isx_state_type st;       // registered state
   isx_state_type next_st;  // next value of the state
   logic isIncrWord;        // incoming word is increment-skip
   logic isOrWord;          // incoming word is or-literal

   // opcode match on the raw word, used in quarter one only
   assign isIncrWord = (instrWord[INSTR_WIDTH-1:OPCODE_LSB] == INCR_SKIP_OPCODE);
   assign isOrWord = (instrWord[INSTR_WIDTH-1:OPCODE_LSB] == OR_LITERAL_OPCODE);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // one pass of the four quarters per instruction cycle
   always_comb begin
      next_st = st;
      unique case (st.phase)
         // quarter one: decode, or idle while skipping
         PH_ONE: begin
            next_st.phase = PH_TWO;
            next_st.addr = instrWord[ADDR_WIDTH-1:0];
            next_st.dest = instrWord[DEST_BIT];
            next_st.literal = instrWord[DATA_WIDTH-1:0];
            if (st.skip) begin
               next_st.kind = OP_IDLE;
            end else if (isIncrWord) begin
               next_st.kind = OP_INCR;
            end else if (isOrWord) begin
               next_st.kind = OP_OR;
            end else begin
               // other instructions belong to other units
               next_st.kind = OP_IDLE;
            end
         end
         // quarter two: read file register or take literal
         PH_TWO: begin
            next_st.phase = PH_THREE;
            if (st.kind == OP_INCR) begin
               next_st.operand = fileRdData;
            end else if (st.kind == OP_OR) begin
               next_st.operand = st.literal;
            end
         end
         // quarter three: compute
         PH_THREE: begin
            next_st.phase = PH_FOUR;
            if (st.kind == OP_INCR) begin
               next_st.result = st.operand + 8'h01;
            end else if (st.kind == OP_OR) begin
               next_st.result = st.operand | st.acc;
            end
         end
         // quarter four: write destination, arm the skip
         PH_FOUR: begin
            next_st.phase = PH_ONE;
            next_st.skip = 1'h0;
            unique case (st.kind)
               OP_INCR: begin
                  // flags are not touched here
                  if (!st.dest) begin
                     next_st.acc = st.result;
                  end
                  if (st.result == 8'h00) begin
                     next_st.skip = 1'h1;
                  end
               end
               OP_OR: begin
                  next_st.acc = st.result;
                  next_st.zero = (st.result == 8'h00);
               end
               OP_IDLE: begin
                  // nothing to write
               end
               default: begin
                  // unused code, treat as idle
                  next_st.kind = OP_IDLE;
               end
            endcase
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // only constants under reset; accumulator and flag start cleared
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st.phase <= PH_ONE;
         st.skip <= 1'h0;
         st.kind <= OP_IDLE;
         st.dest <= 1'h0;
         st.addr <= 7'h00;
         st.literal <= 8'h00;
         st.operand <= 8'h00;
         st.result <= 8'h00;
         st.acc <= ACC_RESET;
         st.zero <= ZERO_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign fileAddr = st.addr;
   assign fileWrData = st.result;
   assign accumulator = st.acc;
   assign zeroFlag = st.zero;
   assign skipActive = st.skip;
   // read strobe in quarter two; a skip cycle never reaches here as incr
   assign fileRdEn = (st.phase == PH_TWO) && (st.kind == OP_INCR);
   // write strobe in quarter four, file destination only
   assign fileWrEn = (st.phase == PH_FOUR) && (st.kind == OP_INCR) && st.dest;
   // quarter indicators decoded from the phase register
   assign quarterPhaseOne = (st.phase == PH_ONE);
   assign quarterPhaseTwo = (st.phase == PH_TWO);
   assign quarterPhaseThree = (st.phase == PH_THREE);
   assign quarterPhaseFour = (st.phase == PH_FOUR);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // a full pass through the quarters
   sequence s_quarters;
      quarterPhaseTwo ##1 quarterPhaseThree ##1 quarterPhaseFour ##1 quarterPhaseOne;
   endsequence

   // a whole no-op cycle
   sequence s_skip_cycle;
      (skipActive && !fileRdEn && !fileWrEn) [*4];
   endsequence

   a_phase_order: assert property (quarterPhaseOne |=> s_quarters)
      else $error("quarter phases out of order");

   a_decode_incr: assert property (quarterPhaseOne && !skipActive && isIncrWord
      |=> st.kind == OP_INCR && fileAddr == $past(instrWord[ADDR_WIDTH-1:0]))
      else $error("increment-skip word not decoded");

   a_incr_value: assert property (quarterPhaseThree && st.kind == OP_INCR
      |=> st.result == 8'($past(st.operand) + 8'h01))
      else $error("increment result wrong");

   a_incr_flag_keep: assert property (quarterPhaseFour && st.kind == OP_INCR
      |=> $stable(zeroFlag))
      else $error("zero flag changed by increment-skip");

   a_incr_to_acc: assert property (quarterPhaseFour && st.kind == OP_INCR && !st.dest
      |=> accumulator == $past(fileWrData) && !$past(fileWrEn))
      else $error("accumulator destination not written");

   a_incr_to_file: assert property (quarterPhaseOne && !skipActive && isIncrWord
      && instrWord[DEST_BIT] |-> ##3 fileWrEn ##1 $stable(accumulator))
      else $error("file destination not written");

   a_skip_on_zero: assert property (quarterPhaseFour && st.kind == OP_INCR
      && fileWrData == 8'h00 |=> s_skip_cycle ##1 !skipActive)
      else $error("zero result did not skip one cycle");

   a_no_skip: assert property (quarterPhaseFour && fileWrData != 8'h00
      |=> !skipActive)
      else $error("nonzero result skipped");

   a_skip_idle: assert property (skipActive && quarterPhaseOne
      |=> st.kind == OP_IDLE ##3 $stable(accumulator))
      else $error("skip cycle was not idle");

   a_read_quarter: assert property (fileRdEn
      |-> quarterPhaseTwo ##2 quarterPhaseFour)
      else $error("file read outside quarter two");

   a_or_result: assert property (quarterPhaseOne && !skipActive && isOrWord
      |-> ##4 accumulator == ($past(accumulator, 4) | $past(instrWord[7:0], 4)))
      else $error("or-literal result wrong");

   a_or_zero: assert property (quarterPhaseFour && st.kind == OP_OR
      |=> zeroFlag == (accumulator == 8'h00))
      else $error("zero flag wrong after or-literal");

   a_or_no_file: assert property (st.kind == OP_OR |-> !fileWrEn && !fileRdEn)
      else $error("or-literal touched the file port");

endmodule // isx_exec

`default_nettype wire

// *** sim/isx_exec_tb.sv ***
// self-checking testbench for the increment-skip and or-literal datapath
`timescale 1ns/1ps
`default_nettype none

module isx_exec_tb
   import isx_pkg::*;
;
   // ------------------------------------------------------------
   // signals and bench state
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [INSTR_WIDTH-1:0] instrWord = '0;
   logic [DATA_WIDTH-1:0] fileRdData = '0;
   logic [ADDR_WIDTH-1:0] fileAddr;
   logic fileRdEn, fileWrEn, zeroFlag, skipActive;
   logic [DATA_WIDTH-1:0] fileWrData, accumulator;
   logic q1, q2, q3, q4; // quarter phase strobes
   logic [31:0] lfsr = 32'h7d4e; // random source, fixed start
   logic [DATA_WIDTH-1:0] mAcc = ACC_RESET; // model accumulator
   logic mZero = ZERO_RESET; // model zero flag
   logic [15:0] rdQ[$]; // expected read address
   logic [15:0] wrQ[$]; // expected address and data of a file write
   logic [15:0] stQ[$]; // expected accumulator, zero flag and skip
   logic [15:0] note; // oldest note taken off a queue
   int badCount = 0;
   int nCompared = 0;
   int cycles = 0;
   int skipLeft = 0; // skip-cycle clocks still to check
   int phaseCnt = 0; // clocks since reset release

   isx_exec isx_exec_inst (.mclk(mclk), .nrst(nrst), .instrWord(instrWord),
      .fileAddr(fileAddr), .fileRdEn(fileRdEn), .fileRdData(fileRdData),
      .fileWrEn(fileWrEn), .fileWrData(fileWrData), .accumulator(accumulator),
      .zeroFlag(zeroFlag), .quarterPhaseOne(q1), .quarterPhaseTwo(q2),
      .quarterPhaseThree(q3), .quarterPhaseFour(q4), .skipActive(skipActive));

   // free-running core clock, 50 ns period
   always #25 mclk = ~mclk;

   // ------------------------------------------------------------
   // comparison and closing
   // ------------------------------------------------------------
   task automatic cmpData(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmpFlag(input logic got, input logic exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic endOfTest();
      $display("compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // galois shift register, one step per call
   function automatic logic [31:0] nextRand(input logic [31:0] v);
      return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
   endfunction

   // ------------------------------------------------------------
   // driver: one instruction, expected results noted in queues
   // ------------------------------------------------------------
   task automatic exec(input logic [13:0] word, input logic [7:0] fd);
      logic [7:0] res;
      // a word is only taken in quarter one of a cycle that is not skipped
      while (!(q1 === 1'b1 && skipActive === 1'b0)) begin
         @(posedge mclk);
         #2;
      end
      instrWord = word;
      res = fd + 8'h01;
      if (word[13:8] == INCR_SKIP_OPCODE) begin
         rdQ.push_back({9'h0, word[6:0]});
         if (word[7]) wrQ.push_back({1'b0, word[6:0], res});
         else mAcc = res;
      end else if (word[13:8] == OR_LITERAL_OPCODE) begin
         mAcc = mAcc | word[7:0];
         mZero = (mAcc == 8'h00);
      end
      @(posedge mclk);
      #2;
      stQ.push_back({6'h0, mAcc, mZero, word[13:8] == INCR_SKIP_OPCODE && res == 8'h00});
      fileRdData = fd;
      // poison word: must be thrown away if the next cycle is a skip
      instrWord = 14'h38ff;
      @(posedge mclk);
      #2;
      // read data no longer valid, so show something different
      fileRdData = ~fd;
   endtask

   // ------------------------------------------------------------
   // monitor: compare outputs against the oldest note
   // ------------------------------------------------------------
   always @(negedge mclk) begin
      if (nrst === 1'b1) begin
         cmpData({12'h0, q4, q3, q2, q1}, 16'h1 << (phaseCnt % 4));
         phaseCnt++;
         if (fileRdEn === 1'b1) begin
            if (rdQ.size() == 0) cmpFlag(fileRdEn, 1'b0);
            else cmpData({9'h0, fileAddr}, rdQ.pop_front());
         end
         if (fileWrEn === 1'b1) begin
            if (wrQ.size() == 0) cmpFlag(fileWrEn, 1'b0);
            else cmpData({1'b0, fileAddr, fileWrData}, wrQ.pop_front());
         end
         if (skipLeft > 0) begin
            cmpFlag(skipActive, 1'b1);
            skipLeft--;
         end else if (q1 === 1'b1) begin
            if (stQ.size() == 0) begin
               cmpFlag(skipActive, 1'b0);
            end else begin
               note = stQ.pop_front();
               cmpData({6'h0, accumulator, zeroFlag, skipActive}, note);
               skipLeft = note[0] ? 3 : 0;
            end
         end
      end
   end

   // hang guard: well above the longest expected run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         badCount++;
         endOfTest();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      #2;
      nrst = 1'b1;
      exec(14'h3800, 8'h00);
      exec(14'h0f00, 8'h99);
      exec(14'h3835, 8'h00);
      exec(14'h0fff, 8'hff);
      exec(14'h0e05, 8'h00);
      for (int i = 0; i < 80; i++) begin
         lfsr = nextRand(lfsr);
         exec({lfsr[1] ? INCR_SKIP_OPCODE : (lfsr[2] ? OR_LITERAL_OPCODE : lfsr[13:8]),
            lfsr[23:16]}, lfsr[4] ? 8'hff : lfsr[31:24]);
      end
      // park an unrecognised word so nothing more reaches the accumulator
      instrWord = 14'h0000;
      repeat (12) @(posedge mclk);
      // every noted read, write and result must have been seen
      cmpData(16'(rdQ.size()), 16'h0000);
      cmpData(16'(wrQ.size()), 16'h0000);
      cmpData(16'(stQ.size()), 16'h0000);
      endOfTest();
   end

endmodule // isx_exec_tb

`default_nettype wire
